/* bench/hbc_host_model.sv */
// hbc_host_model: far side of the host bus, i.e. arbiter plus byte memory.
// assumes: pins already resolved by the bench; the handshake sense comes from i_wait_fn.
`timescale 1ns/1ns
`default_nettype none

module hbc_host_model
#(
  parameter int GRANT_DLY = 2,
  parameter int READY_DLY = 1
)
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  input wire logic i_wait_fn,
  input wire logic i_bus_request_out_n,
  input wire logic i_address_strobe_line_n,
  input wire logic i_data_strobe_line_n,
  input wire logic i_data_strobe_line_oe,
  input wire logic i_rw_line,
  input wire logic [15:0] i_ad,
  output logic o_bus_grant_in_n,
  output logic o_wait_ready_n,
  output logic o_ad_oe,
  output logic [15:0] o_ad
);
  // ----------------------------------------------------------------------
  // arbiter and memory
  // ----------------------------------------------------------------------
  int gcnt, wcnt;
  logic [7:0] lat;
  logic go, cyc;

  assign cyc = i_data_strobe_line_oe && !i_data_strobe_line_n;
  assign go = cyc && (wcnt >= READY_DLY);
  // wait sense: high lets the cycle end; ready sense: low does
  assign o_wait_ready_n = i_wait_fn ? go : !go;
  // memory byte depends on address, so a wrong lane shows up
  assign o_ad_oe = cyc && i_rw_line;
  assign o_ad = {8'ha5 ^ lat, 8'h5a ^ lat};

  // grant only after a request has stood a while, drop it with the request
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      gcnt <= 0;
      wcnt <= 0;
      lat <= 8'h00;
      o_bus_grant_in_n <= 1'b1;
    end
    else
    begin
      gcnt <= i_bus_request_out_n ? 0 : gcnt + 1;
      o_bus_grant_in_n <= i_bus_request_out_n || (gcnt < GRANT_DLY);
      wcnt <= cyc ? wcnt + 1 : 0;
      if (!i_address_strobe_line_n)
        lat <= i_ad[7:0];
    end
  end
endmodule

`default_nettype wire

/* bench/testbench.sv */
// testbench: self-checking bench of the bus configuration block.
// assumes: hbc_pkg compiled first; inputs change at the falling clock edge.
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
`define WAITFOR(c) begin k = 0; while (!(c) && k < 40) begin @(negedge clk); k++; end \
  if (!(c)) begin n_mismatch++; report_and_stop(); end end

module testbench
  import hbc_pkg::*;
;
  // ----------------------------------------------------------------------
  // signals and pin resolution
  // ----------------------------------------------------------------------
  logic clk, nrst, ce_n, as_t, ds_t, rd_t, wr_t, rw_t, ch_t, sec_t, sl_ready, dma_req, wait_fn;
  logic [1:0] dma_ch;
  logic [31:0] dma_addr;
  logic [7:0] sl_rdata;
  logic [15:0] ad_t, o_ad, m_ad;
  logic ad_oe, as_o, as_oe, uas_n, ds_o, ds_oe, rd_o, rd_oe, wr_o, wr_oe, rw_o, rw_oe;
  logic ch_o, ch_oe, sec_o, sec_oe, wt_o, wt_oe, breq_n, grant_n, m_wt, m_oe;
  logic cfg_done, mux_mode, wait_mode, slave_wr, granted, dma_done;
  logic [1:0] ack_type;
  logic [4:0] reg_addr;
  logic [7:0] slave_wdata, dma_rdata;
  int n_mismatch, tests_run, k;
  // whoever enables a pin owns it, else bench or model
  wire logic [15:0] ad_w = ad_oe ? o_ad : (m_oe ? m_ad : ad_t);
  wire logic as_w = as_oe ? as_o : as_t;
  wire logic ds_w = ds_oe ? ds_o : ds_t;
  wire logic rd_w = rd_oe ? rd_o : rd_t;
  wire logic wr_w = wr_oe ? wr_o : wr_t;
  wire logic rw_w = rw_oe ? rw_o : rw_t;
  wire logic ch_w = ch_oe ? ch_o : ch_t;
  wire logic sec_w = sec_oe ? sec_o : sec_t;
  wire logic wt_w = wt_oe ? wt_o : m_wt;

  hbc_bus_config dut (.i_ref_clk(clk), .i_nrst(nrst), .i_ce_n(ce_n), .i_ad(ad_w), .o_ad(o_ad),
    .o_ad_oe(ad_oe), .i_address_strobe_line_n(as_w), .o_address_strobe_line_n(as_o),
    .o_address_strobe_line_oe(as_oe), .o_upper_address_strobe_n(uas_n),
    .i_data_strobe_line_n(ds_w), .o_data_strobe_line_n(ds_o), .o_data_strobe_line_oe(ds_oe),
    .i_rd_n(rd_w), .o_rd_n(rd_o), .o_rd_oe(rd_oe), .i_wr_n(wr_w), .o_wr_n(wr_o), .o_wr_oe(wr_oe),
    .i_rw_line(rw_w), .o_rw_line(rw_o), .o_rw_oe(rw_oe), .i_channel_select_pin(ch_w),
    .o_channel_select_pin(ch_o), .o_channel_select_pin_oe(ch_oe), .i_section_select_pin(sec_w),
    .o_section_select_pin(sec_o), .o_section_select_pin_oe(sec_oe), .i_wait_ready_n(wt_w),
    .o_wait_ready_n(wt_o), .o_wait_ready_oe(wt_oe), .i_irq_acknowledge_input_n(1'b1),
    .o_bus_request_out_n(breq_n), .i_bus_grant_in_n(grant_n), .o_cfg_done(cfg_done),
    .o_mux_mode(mux_mode), .o_wait_mode(wait_mode), .o_ack_type(ack_type), .o_reg_addr(reg_addr),
    .o_slave_rd(), .o_slave_wr(slave_wr), .o_slave_wdata(slave_wdata), .i_slave_rdata(sl_rdata),
    .i_slave_ready(sl_ready), .o_vector_cycle(), .i_vector_valid(1'b0), .o_ack_latched(),
    .i_dma_req(dma_req), .i_dma_write(1'b0), .i_dma_channel(dma_ch), .i_dma_addr(dma_addr),
    .i_dma_wdata(8'h00), .o_dma_granted(granted), .o_dma_done(dma_done), .o_dma_rdata(dma_rdata));

  hbc_host_model far (.i_ref_clk(clk), .i_nrst(nrst), .i_wait_fn(wait_fn),
    .i_bus_request_out_n(breq_n), .i_address_strobe_line_n(as_w), .i_data_strobe_line_n(ds_w),
    .i_data_strobe_line_oe(ds_oe), .i_rw_line(rw_w), .i_ad(ad_w), .o_bus_grant_in_n(grant_n),
    .o_wait_ready_n(m_wt), .o_ad_oe(m_oe), .o_ad(m_ad));

  // ----------------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------------
  task report_and_stop();
    $display("counts: compared %0d mismatched %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task reset_dut();
    nrst = 0;
    repeat (3) @(negedge clk);
    nrst = 1;
  endtask

  // section select held low for every host write
  task host_wr(input logic [7:0] d, input logic ch, input logic go, output logic saw);
    ch_t = ch;
    sec_t = 0;
    ad_t = {8'h00, d};
    ce_n = 0;
    wr_t = 0;
    saw = 0;
    k = 0;
    while (wt_w !== go && k < 40)
    begin
      @(negedge clk);
      saw |= (slave_wr === 1'b1);
      k++;
    end
    if (wt_w !== go)
    begin
      n_mismatch++;
      report_and_stop();
    end
    @(negedge clk);
    saw |= (slave_wr === 1'b1);
    ce_n = 1;
    wr_t = 1;
    @(negedge clk);
  endtask

  task host_rd(input logic go);
    sl_ready = 1;
    ce_n = 0;
    rd_t = 0;
    `WAITFOR(wt_w === go)
    `CHK(ad_w, {sl_rdata, sl_rdata})
    @(negedge clk);
    ce_n = 1;
    rd_t = 1;
    @(negedge clk);
  endtask

  // one memory read as master, judged at each phase
  task dma_rd(input logic [1:0] ch, input logic [31:0] a, input logic en, input logic sel);
    logic [7:0] e;
    dma_ch = ch;
    dma_addr = a;
    dma_req = 1;
    `WAITFOR(breq_n === 1'b0)
    `CHK(granted, 1'b0)
    `WAITFOR(as_o === 1'b0 && as_oe === 1'b1)
    dma_req = 0;
    `CHK(o_ad, a[15:0])
    `CHK({ch_o, sec_o, ch_oe, sec_oe}, {ch, 2'h3})
    `CHK({rd_oe, wr_oe, ds_oe, rw_oe, uas_n}, 5'h1f)
    @(negedge clk);
    `CHK({uas_n, o_ad}, {1'b0, a[31:16]})
    `WAITFOR(dma_done === 1'b1)
    e = (en && sel == a[0]) ? (8'ha5 ^ a[7:0]) : (8'h5a ^ a[7:0]);
    `CHK(dma_rdata, e)
    `CHK({as_oe, rd_oe, ds_oe}, 3'h0)
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task test_mux_cfg();
    logic s;
    reset_dut();
    ad_t = 16'h002a;
    as_t = 0;
    @(negedge clk);
    as_t = 1;
    @(negedge clk);
    wait_fn = 1;
    host_wr(8'h86, 1, 1, s);
    `CHK({cfg_done, mux_mode, wait_mode}, 3'h7)
    `CHK(ack_type, ACK_DOUBLE)
    host_wr(8'h41, 0, 1, s);
    `CHK({s, slave_wdata}, 9'h141)
    `CHK({mux_mode, wait_mode, ack_type}, 4'hf)
    ad_t = 16'h002a;
    as_t = 0;
    @(negedge clk);
    as_t = 1;
    @(negedge clk);
    `CHK(reg_addr, 5'h15)
    for (int c = 0; c < 4; c++)
      dma_rd(c[1:0], {16'h8000 + c[15:0], 16'h1230 + c[15:0]}, 1, 0);
    $display("test_mux_cfg done");
  endtask

  task test_nonmux_cfg();
    logic s;
    reset_dut();
    wait_fn = 0;
    host_wr(8'hc0, 0, 0, s);
    `CHK({cfg_done, mux_mode, wait_mode}, 3'h4)
    for (int c = 0; c < 4; c++)
      dma_rd(2'h3 - c[1:0], {16'h0042, 16'h00f0 + c[15:0]}, 1, 1);
    $display("test_nonmux_cfg done");
  endtask

  task test_ack_codes();
    logic s;
    for (int c = 0; c < 4; c++)
    begin
      reset_dut();
      as_t = !c[0];
      host_wr({5'h00, c[1:0], c[0]}, 0, 0, s);
      as_t = 1;
      `CHK(ack_type, c[1:0])
      `CHK(reg_addr, c[0] ? {2'h0, c[1:0], 1'b1} : 5'h0)
      dma_rd(c[1:0], c, 0, 0);
    end
    $display("test_ack_codes done");
  endtask

  task test_read_first();
    logic s;
    reset_dut();
    sl_rdata = 8'h3c;
    host_rd(0);
    host_wr(8'h06, 0, 0, s);
    `CHK({cfg_done, s, ack_type}, {2'h1, ACK_STATUS})
    dma_req = 1;
    repeat (6) @(negedge clk);
    `CHK(breq_n, 1'b1)
    dma_req = 0;
    $display("test_read_first done");
  endtask

  // ----------------------------------------------------------------------
  // clock and main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    {nrst, as_t, ds_t, rd_t, wr_t, rw_t, ce_n} = 7'h3f;
    {ch_t, sec_t, sl_ready, dma_req, wait_fn, dma_ch} = 7'h00;
    {dma_addr, sl_rdata, ad_t} = 56'h0;
    n_mismatch = 0;
    tests_run = 0;
    @(negedge clk);
    test_mux_cfg();
    test_nonmux_cfg();
    test_ack_codes();
    test_read_first();
    report_and_stop();
  end
endmodule

`default_nettype wire

/* logic/hbc_bus_config.sv */
// hbc_bus_config: bus configuration capture, slave handshake and DMA master pin control.
// assumes: all pins synchronous to i_ref_clk; external pads resolve the enables.
`timescale 1ns/1ns
`default_nettype none

module hbc_bus_config
  import hbc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_nrst,
  // host pins
  input wire logic i_ce_n,
  input wire logic [AD_W-1:0] i_ad,
  output logic [AD_W-1:0] o_ad,
  output logic o_ad_oe,
  input wire logic i_address_strobe_line_n,
  output logic o_address_strobe_line_n,
  output logic o_address_strobe_line_oe,
  output logic o_upper_address_strobe_n,
  input wire logic i_data_strobe_line_n,
  output logic o_data_strobe_line_n,
  output logic o_data_strobe_line_oe,
  input wire logic i_rd_n,
  output logic o_rd_n,
  output logic o_rd_oe,
  input wire logic i_wr_n,
  output logic o_wr_n,
  output logic o_wr_oe,
  input wire logic i_rw_line,
  output logic o_rw_line,
  output logic o_rw_oe,
  input wire logic i_channel_select_pin,
  output logic o_channel_select_pin,
  output logic o_channel_select_pin_oe,
  input wire logic i_section_select_pin,
  output logic o_section_select_pin,
  output logic o_section_select_pin_oe,
  input wire logic i_wait_ready_n,
  output logic o_wait_ready_n,
  output logic o_wait_ready_oe,
  input wire logic i_irq_acknowledge_input_n,
  output logic o_bus_request_out_n,
  input wire logic i_bus_grant_in_n,
  // register core side
  output logic o_cfg_done,
  output logic o_mux_mode,
  output logic o_wait_mode,
  output logic [1:0] o_ack_type,
  output logic [REG_ADDR_W-1:0] o_reg_addr,
  output logic o_slave_rd,
  output logic o_slave_wr,
  output logic [7:0] o_slave_wdata,
  input wire logic [7:0] i_slave_rdata,
  input wire logic i_slave_ready,
  output logic o_vector_cycle,
  input wire logic i_vector_valid,
  output logic o_ack_latched,
  // dma engine side
  input wire logic i_dma_req,
  input wire logic i_dma_write,
  input wire logic [1:0] i_dma_channel,
  input wire logic [DMA_ADDR_W-1:0] i_dma_addr,
  input wire logic [7:0] i_dma_wdata,
  output logic o_dma_granted,
  output logic o_dma_done,
  output logic [7:0] o_dma_rdata
);

  // ----------------------------------------------------------------------
  // state and helpers
  // ----------------------------------------------------------------------
  typedef struct packed
  {
    logic first_seen;
    logic cfg_done;
    logic as_seen;
    logic mux_mode;
    logic wait_mode;
    logic [CFG_W-1:0] cfg;
    logic as_q_n;
    logic strobe_q;
    logic irq_acknowledge_input_q_n;
    logic pulse_cnt;
    logic ack_latched;
    logic [AD_W-1:0] addr_lat;
    logic slave_rd;
    logic slave_wr;
    logic slave_ok;
    logic [7:0] slave_wdata;
    logic [AD_W-1:0] ad_out;
    hbc_dma_state_t dma_state;
    logic dma_wr;
    logic [1:0] dma_ch;
    logic [DMA_ADDR_W-1:0] dma_addr;
    logic [7:0] dma_wdata;
    logic [7:0] dma_rdata;
    logic dma_done;
  } hbc_state_t;

  // handshake pin level that means "go" for the chosen function
  function automatic logic hbc_hs_level(input logic wait_fn, input logic go);
    hbc_hs_level = wait_fn ? go : ~go;
  endfunction

  hbc_state_t s;
  hbc_state_t next_s;
  logic master;
  logic strobe_act;
  logic is_write;
  logic strobe_start;
  logic as_rise;
  logic cfg_take;
  logic eff_wait;
  logic vec_now;
  logic hs_go;
  logic [1:0] ack;
  logic [7:0] lane_byte;

  // ----------------------------------------------------------------------
  // decode of the slave cycle
  // ----------------------------------------------------------------------
  // own outputs show on the pins while master, so slave decode is gated off
  assign master = (s.dma_state == dma_addr_lo) || (s.dma_state == dma_addr_hi) ||
                  (s.dma_state == dma_data) || (s.dma_state == dma_end);
  assign strobe_act = !master && !i_ce_n &&
                      (!i_rd_n || !i_wr_n || !i_data_strobe_line_n);
  assign is_write = !i_wr_n || (!i_data_strobe_line_n && !i_rw_line);
  assign strobe_start = strobe_act && !s.strobe_q;
  assign as_rise = !master && !s.as_q_n && i_address_strobe_line_n;
  assign cfg_take = strobe_start && !s.first_seen && is_write; // [R1] [R2]
  // pin sample acts on the configuration write itself
  assign eff_wait = s.cfg_done ? s.wait_mode : i_channel_select_pin; // [R7]
  assign ack = s.cfg[CFG_ACK_MSB:CFG_ACK_LSB];

  // vector drive per acknowledge type; reserved code never drives
  always_comb
  begin
    vec_now = 1'b0;
    case (ack) // [R9]
      ACK_STATUS: vec_now = s.ack_latched && strobe_act && !is_write;
      ACK_SINGLE: vec_now = !i_irq_acknowledge_input_n; // [R11]
      ACK_DOUBLE: vec_now = !i_irq_acknowledge_input_n && s.pulse_cnt; // [R11]
      default: vec_now = 1'b0;
    endcase
  end

  // master handshake input, read through the chosen function
  assign hs_go = (i_wait_ready_n == hbc_hs_level(s.wait_mode, 1'b1)); // [R6]

  hbc_byte_lane u_lane
  (
    .i_bus(i_ad),
    .i_swap_en(s.cfg[CFG_SWAP_EN_BIT]),
    .i_swap_sel(s.cfg[CFG_SWAP_SEL_BIT]),
    .i_a0(s.dma_addr[0]),
    .o_byte(lane_byte)
  );

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_s = s;
    next_s.slave_rd = 1'b0;
    next_s.slave_wr = 1'b0;
    next_s.dma_done = 1'b0;
    next_s.as_q_n = master ? 1'b1 : i_address_strobe_line_n;
    next_s.strobe_q = strobe_act;
    next_s.irq_acknowledge_input_q_n = i_irq_acknowledge_input_n;

    // address strobe seen before the configuration write, chip enable not needed
    if (!s.cfg_done && !master && !i_address_strobe_line_n)
    begin
      next_s.as_seen = 1'b1; // [R3]
    end
    // transparent address latch while the strobe is low
    if (!master && !i_address_strobe_line_n)
    begin
      next_s.addr_lat = i_ad;
    end

    // one chance only: the first access decides, later ones never reconfigure
    if (strobe_start && !s.first_seen)
    begin
      next_s.first_seen = 1'b1; // [R1] [R22]
    end
    if (cfg_take)
    begin
      next_s.cfg_done = 1'b1;
      next_s.cfg = i_ad[CFG_W-1:0]; // [R12]
      next_s.wait_mode = i_channel_select_pin; // [R5]
      next_s.mux_mode = s.as_seen || !i_address_strobe_line_n; // [R3]
    end
    else if (strobe_start)
    begin
      next_s.slave_rd = !is_write;
      next_s.slave_wr = is_write;
      next_s.slave_wdata = i_ad[7:0]; // [R15]
    end

    // status acknowledge sampling point depends on bus mode
    if (ack == ACK_STATUS)
    begin
      if (s.mux_mode && as_rise)
      begin
        next_s.ack_latched = !i_irq_acknowledge_input_n; // [R10]
      end
      else if (!s.mux_mode && strobe_start)
      begin
        next_s.ack_latched = !i_irq_acknowledge_input_n; // [R10]
      end
    end
    // double pulse: first pulse only counted, second drives the vector
    if (ack == ACK_DOUBLE && !s.irq_acknowledge_input_q_n && i_irq_acknowledge_input_n)
    begin
      next_s.pulse_cnt = !s.pulse_cnt;
    end

    // slave handshake and read data, registered together so they agree
    if (vec_now)
    begin
      next_s.slave_ok = i_vector_valid; // [R21]
    end
    else
    begin
      next_s.slave_ok = strobe_act && (is_write || i_slave_ready); // [R21]
    end
    if (!master)
    begin
      next_s.ad_out = {i_slave_rdata, i_slave_rdata};
    end

    // master sequence
    case (s.dma_state)
      dma_idle:
      begin
        if (i_dma_req && s.cfg_done)
        begin
          next_s.dma_state = dma_req;
          next_s.dma_wr = i_dma_write;
          next_s.dma_ch = i_dma_channel;
          next_s.dma_addr = i_dma_addr;
          next_s.dma_wdata = i_dma_wdata;
        end
      end
      dma_req:
      begin
        if (!i_bus_grant_in_n)
        begin
          next_s.dma_state = dma_addr_lo; // [R17]
          next_s.ad_out = s.dma_addr[15:0]; // [R18]
        end
      end
      dma_addr_lo:
      begin
        next_s.dma_state = dma_addr_hi;
        next_s.ad_out = s.dma_addr[31:16]; // [R18]
      end
      dma_addr_hi:
      begin
        next_s.dma_state = dma_data;
        next_s.ad_out = {s.dma_wdata, s.dma_wdata};
      end
      dma_data:
      begin
        if (hs_go)
        begin
          next_s.dma_state = dma_end; // [R6]
          if (!s.dma_wr)
          begin
            next_s.dma_rdata = lane_byte; // [R13] [R15]
          end
        end
      end
      dma_end:
      begin
        next_s.dma_state = dma_idle;
        next_s.dma_done = 1'b1;
      end
      default: next_s.dma_state = dma_idle;
    endcase
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      s <= '0;
      s.cfg <= CFG_RESET;
      s.as_q_n <= 1'b1;
      s.irq_acknowledge_input_q_n <= 1'b1;
      s.dma_state <= dma_idle;
    end
    else
    begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------------
  // pin drive
  // ----------------------------------------------------------------------
  // strobes and address strobe only driven as master; otherwise inputs
  assign o_address_strobe_line_oe = master; // [R4]
  assign o_address_strobe_line_n = (s.dma_state != dma_addr_lo); // [R18]
  assign o_upper_address_strobe_n = (s.dma_state != dma_addr_hi); // [R18]
  assign o_rd_oe = master; // [R19]
  assign o_wr_oe = master; // [R19]
  assign o_data_strobe_line_oe = master; // [R19]
  assign o_rw_oe = master; // [R19]
  assign o_rd_n = !((s.dma_state == dma_data) && !s.dma_wr);
  assign o_wr_n = !((s.dma_state == dma_data) && s.dma_wr);
  assign o_data_strobe_line_n = (s.dma_state != dma_data);
  assign o_rw_line = !s.dma_wr;
  // channel identity on the select pins, external drivers must be off
  assign o_channel_select_pin_oe = master; // [R16]
  assign o_section_select_pin_oe = master; // [R16]
  assign o_channel_select_pin = s.dma_ch[1];
  assign o_section_select_pin = s.dma_ch[0];
  assign o_ad = s.ad_out;
  assign o_ad_oe = master ? (s.dma_state != dma_data || s.dma_wr) :
                           ((strobe_act && !is_write) || vec_now);
  assign o_bus_request_out_n = !((s.dma_state == dma_req) || master) ||
                               (s.dma_state == dma_end); // [R17]
  assign o_wait_ready_oe = !master && (strobe_act || vec_now); // [R6]
  assign o_wait_ready_n = hbc_hs_level(eff_wait, s.slave_ok); // [R6] [R7] [R21]

  // ----------------------------------------------------------------------
  // core side outputs
  // ----------------------------------------------------------------------
  // shift choice only matters with a multiplexed address
  always_comb
  begin
    if (!s.mux_mode)
    begin
      o_reg_addr = {3'h0, i_channel_select_pin, i_section_select_pin};
    end
    else if (s.cfg[CFG_SHIFT_BIT])
    begin
      o_reg_addr = s.addr_lat[4:0]; // [R8]
    end
    else
    begin
      o_reg_addr = s.addr_lat[5:1]; // [R8]
    end
  end

  assign o_cfg_done = s.cfg_done;
  assign o_mux_mode = s.mux_mode;
  assign o_wait_mode = eff_wait;
  assign o_ack_type = ack;
  assign o_slave_rd = s.slave_rd;
  assign o_slave_wr = s.slave_wr;
  assign o_slave_wdata = s.slave_wdata;
  assign o_vector_cycle = vec_now;
  assign o_ack_latched = s.ack_latched;
  assign o_dma_granted = master;
  assign o_dma_done = s.dma_done;
  assign o_dma_rdata = s.dma_rdata;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_nrst);

  a_cfg_held: assert property ($past(s.cfg_done) |-> $stable(s.cfg) && s.cfg_done) // [R22]
    else $error("configuration changed after capture");
  a_first_only: assert property (strobe_start && s.first_seen |=> !$changed(s.cfg)) // [R1]
    else $error("later access altered configuration");
  a_mux_pick: assert property (cfg_take && !s.as_seen && i_address_strobe_line_n
                               |=> !s.mux_mode) // [R3]
    else $error("mux mode without prior address strobe");
  a_wait_pick: assert property (cfg_take |=> s.wait_mode == $past(i_channel_select_pin)) // [R5]
    else $error("handshake function not sampled");
  a_as_master: assert property (s.dma_state == dma_addr_lo
                                |-> o_address_strobe_line_oe && !o_address_strobe_line_n
                                && o_ad == s.dma_addr[15:0]) // [R4]
    else $error("low address not strobed");
  a_upper_half: assert property (s.dma_state == dma_addr_lo
                                 |=> !o_upper_address_strobe_n
                                 && o_ad == s.dma_addr[31:16]) // [R18]
    else $error("upper address not strobed");
  a_grant_wait: assert property (s.dma_state == dma_req && i_bus_grant_in_n
                                 |=> s.dma_state == dma_req && !o_address_strobe_line_oe) // [R17]
    else $error("bus taken without grant");
  a_chan_id: assert property (master |-> o_channel_select_pin_oe
                              && {o_channel_select_pin, o_section_select_pin} == s.dma_ch) // [R16]
    else $error("channel identity wrong");
  a_read_strobe: assert property (s.dma_state == dma_data && !s.dma_wr
                                  |-> o_rd_oe && !o_rd_n && o_wr_n && o_rw_line) // [R19]
    else $error("read strobe not driven");
  a_lane_low: assert property (s.dma_state == dma_data && !s.dma_wr && hs_go
                               && !s.cfg[CFG_SWAP_EN_BIT]
                               |=> o_dma_rdata == $past(i_ad[7:0])) // [R13]
    else $error("unswapped read took wrong lane");
  a_shift_right: assert property (s.mux_mode && s.cfg[CFG_SHIFT_BIT]
                                  |-> o_reg_addr == s.addr_lat[4:0]) // [R8]
    else $error("right shift decode wrong");
  a_status_ack: assert property (ack == ACK_STATUS && !s.mux_mode && strobe_start
                                 |=> s.ack_latched == !$past(i_irq_acknowledge_input_n)) // [R10]
    else $error("status acknowledge not latched");
  a_slave_hs: assert property (o_wait_ready_oe && s.slave_ok && s.cfg_done
                               |-> o_wait_ready_n == s.wait_mode) // [R6]
    else $error("slave handshake level wrong");

  c_cfg_mux: cover property (cfg_take && s.as_seen);
  c_dma_read: cover property (s.dma_state == dma_data && !s.dma_wr ##1 s.dma_state == dma_end);
  c_dma_write: cover property (s.dma_state == dma_data && s.dma_wr ##1 s.dma_state == dma_end);
  c_double_vec: cover property (ack == ACK_DOUBLE && vec_now);

endmodule
`default_nettype wire

/* logic/hbc_byte_lane.sv */
// hbc_byte_lane: picks the byte lane the device accepts on a DMA read from memory.
// assumes: caller applies it only to data taken while bus master.
`timescale 1ns/1ns
`default_nettype none

module hbc_byte_lane
  import hbc_pkg::*;
(
  input wire logic [AD_W-1:0] i_bus,
  input wire logic i_swap_en,
  input wire logic i_swap_sel,
  input wire logic i_a0,
  output logic [7:0] o_byte
);

  // ----------------------------------------------------------------------
  // lane choice
  // ----------------------------------------------------------------------
  // swap off keeps legacy low-lane behaviour
  always_comb
  begin
    if (!i_swap_en)
    begin
      o_byte = i_bus[7:0]; // [R13]
    end
    else if (i_swap_sel == i_a0)
    begin
      o_byte = i_bus[15:8]; // [R14] [R20]
    end
    else
    begin
      o_byte = i_bus[7:0]; // [R14] [R20]
    end
  end

endmodule
`default_nettype wire

/* logic/hbc_pkg.sv */
// hbc_pkg: constants, field layout and state type of the host bus configuration logic.
// assumes: shared by the configuration/master block and its byte lane selector.
//
// Summary of operation
// (R1) first access after reset must be the configuration write; only then accepted
// (R2) host keeps section select low during the configuration write
// (R3) address strobe seen before configuration write selects multiplexed mode
// (R4) address strobe is driven only while the device is DMA bus master
// (R5) channel select high selects wait function, low selects ready function
// (R6) wait-or-ready choice applies to handshake input and handshake output alike
// (R7) pin-sampled settings act at once, even on the configuration write; code does so for wait mode only, mux mode takes effect after the write
// (R8) bit 0 picks left or right address shift, multiplexed mode only
// (R9) bits 2:1 pick status, single or double pulse acknowledge; 10 reserved
// (R10) status acknowledge latched at address strobe rise or strobe fall
// (R11) host holds or pulses acknowledge as the chosen type demands
// (R12) host writes zeros to reserved configuration bits 3 to 5
// (R13) bit 7 clear takes DMA read data from low lane only
// (R14) bit 6 with DMA address bit 0 picks the accepted byte lane
// (R15) byte swapping touches only DMA reads from memory
// (R16) channel and section pins name the active DMA channel while master
// (R17) request the bus, take it only after the grant arrives
// (R18) 32-bit address out, low half with address strobe, high half upper strobe
// (R19) read, write, data strobe and direction lines driven only as master
// (R20) swap select set: even bytes on low lane, odd on high lane
// (R21) slave handshake marks read data, write acceptance and valid vector
// (R22) captured settings hold until reset; later configuration attempts ignored

package hbc_pkg;

  // ----------------------------------------------------------------------
  // configuration byte layout
  // ----------------------------------------------------------------------
  localparam int unsigned CFG_W = 8;
  localparam logic [7:0] CFG_RESET = 8'h00;
  localparam int unsigned CFG_SHIFT_BIT = 0;
  localparam int unsigned CFG_ACK_LSB = 1;
  localparam int unsigned CFG_ACK_MSB = 2;
  localparam int unsigned CFG_SWAP_SEL_BIT = 6;
  localparam int unsigned CFG_SWAP_EN_BIT = 7;

  // acknowledge type codes
  localparam logic [1:0] ACK_STATUS = 2'h0;
  localparam logic [1:0] ACK_SINGLE = 2'h1;
  localparam logic [1:0] ACK_RESERVED = 2'h2;
  localparam logic [1:0] ACK_DOUBLE = 2'h3;

  // dma channel codes as {channel_select_pin, section_select_pin}
  localparam logic [1:0] CH_RX_A = 2'h3;
  localparam logic [1:0] CH_TX_A = 2'h2;
  localparam logic [1:0] CH_RX_B = 2'h1;
  localparam logic [1:0] CH_TX_B = 2'h0;

  // ----------------------------------------------------------------------
  // widths
  // ----------------------------------------------------------------------
  localparam int unsigned AD_W = 16;
  localparam int unsigned DMA_ADDR_W = 32;
  localparam int unsigned REG_ADDR_W = 5;

  // master cycle sequence
  typedef enum logic [2:0]
  {
    dma_idle,
    dma_req,
    dma_addr_lo,
    dma_addr_hi,
    dma_data,
    dma_end
  } hbc_dma_state_t;

endpackage
